// ==== core/acs_cal_seq.sv ====
// Overview of operation
// [RQ1] calibration command accepted at any moment
// [RQ2] 24-bit coefficients readable and writable by host
// [RQ3] subtract offset, then multiply by normalized gain
// [RQ4] zero-scale to offset, full-scale to gain
// [RQ5] 33-bit arithmetic, 16 or 24-bit result
// [RQ6] code 100: internal zero-scale, inputs shorted
// [RQ7] internal zero-scale lasts 22 or 24 periods
// [RQ8] internal full-scale lasts 44 or 48 periods
// [RQ9] op-select returns to 000 after calibration
// [RQ10] ready high during calibration, low when done
// [RQ11] calibration gives no result; host restarts conversion
// [RQ12] ready rises within one modulator cycle
// [RQ13] host ignores ready one modulator cycle
// [RQ14] bipolar zero input gives code 800000
// [RQ15] code 101: internal full-scale from reference
// [RQ16] internal full-scale includes zero-scale step
// [RQ17] host follows internal full-scale with zero-scale
// [RQ18] host does zero-scale before system full-scale
// [RQ19] skip ignored, second filter used in calibration
// [RQ20] host calibrates with chop as later used
// [RQ21] gain stage follows range field during calibration
// [RQ22] host calibrates low ranges on 80 mV range
// [RQ23] coefficients valid at every output rate
// [RQ24] code 110: system zero-scale on input pins
// [RQ25] code 111: system full-scale on input pins
`timescale 1ns/1ps
module acs_cal_seq (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // filtered word from the digital filter
  input  wire logic [acs_pkg::COEF_W-1:0] filt_data,
  // front-end control
  output logic                            mod_tick,
  output acs_pkg::acs_in_t                in_sel,
  output logic [acs_pkg::RANGE_W-1:0]     pga_gain,
  output logic                            skip_eff,
  output logic                            chop_out,
  // conversion results
  output logic                            ready_n,
  output logic                            result_valid,
  output logic [acs_pkg::COEF_W-1:0]      result_data
);
  import acs_pkg::*;

  localparam int ARM_MAX = MOD_DIV; // longest wait to raise ready

  // bus capture
  logic               addr_ok;   // address phase accepted
  logic               wr_q;      // write data phase pending
  logic [DEC_W-1:0]   addr_q;    // latched write address
  logic               mode_wr;   // write strobes per register
  logic               filt_wr;
  logic               offs_wr;
  logic               gain_wr;
  logic               data_rd;   // result read, releases ready
  logic [31:0]        rd_word;   // read mux output
  logic [31:0]        hrdata_reg;
  // control registers
  logic [OP_W-1:0]    op_reg;
  logic [RANGE_W-1:0] range_reg;
  logic               bipolar_reg;
  logic               word24_reg;
  logic [CHAN_W-1:0]  chan_reg;
  logic [SF_W-1:0]    sf_reg;
  logic               chop_reg;
  logic               skip_reg;
  logic [CHAN_W-1:0]  chan_wr;   // written channel, zeroed if out of range
  // coefficient storage, one word per channel
  logic [COEF_W-1:0]  offs_mem [N_CHAN];
  logic [COEF_W-1:0]  gain_mem [N_CHAN];
  // sequencer
  acs_state_t         state_reg;
  logic [CNT_W-1:0]   cnt_reg;   // output periods in current step
  logic [CNT_W-1:0]   step_len;
  logic               out_tick;  // one output period elapsed
  logic [PER_W-1:0]   per_len;   // output period in modulator cycles
  logic               in_cal;
  logic               cal_start;
  logic               last_tick;
  logic               zs_store;
  logic               fs_store;
  logic               cal_done;
  logic               conv_valid;
  logic               ready_n_reg;
  // datapath
  logic signed [ACC_W-1:0]           diff;
  logic signed [ACC_W+COEF_W:0]      prod;
  logic signed [ACC_W-1:0]           acc;
  logic [COEF_W-1:0]                 code;
  logic [COEF_W-1:0]                 result_reg;
  logic                              valid_reg;

  // zero-wait slave: always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign addr_ok   = hsel && hready && htrans[1];
  assign data_rd   = addr_ok && !hwrite && (haddr[DEC_W-1:0] == DATA_OFS);
  assign mode_wr   = wr_q && (addr_q == MODE_OFS);
  assign filt_wr   = wr_q && (addr_q == FILT_OFS);
  assign offs_wr   = wr_q && (addr_q == OFFS_OFS);
  assign gain_wr   = wr_q && (addr_q == GAIN_OFS);

  // address phase capture; hsize ignored, only words are mapped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q   <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_q <= addr_ok && hwrite;
      if (addr_ok) begin
        addr_q <= haddr[DEC_W-1:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[DEC_W-1:0])
      MODE_OFS: begin
        rd_word[OP_LSB +: OP_W]       = op_reg;
        rd_word[RANGE_LSB +: RANGE_W] = range_reg;
        rd_word[BIPOLAR_BIT]          = bipolar_reg;
        rd_word[WORD24_BIT]           = word24_reg;
        rd_word[CHAN_LSB +: CHAN_W]   = chan_reg;
      end
      FILT_OFS: begin
        rd_word[SF_LSB +: SF_W] = sf_reg;
        rd_word[CHOP_BIT]       = chop_reg;
        rd_word[SKIP_BIT]       = skip_reg;
      end
      STAT_OFS: begin
        rd_word[ST_RDYN_BIT] = ready_n_reg;
        rd_word[ST_CAL_BIT]  = in_cal;
        rd_word[ST_FS_BIT]   = (state_reg == ACS_FS);
      end
      DATA_OFS: rd_word[COEF_W-1:0] = result_reg;
      OFFS_OFS: rd_word[COEF_W-1:0] = offs_mem[chan_reg]; // [RQ2]
      GAIN_OFS: rd_word[COEF_W-1:0] = gain_mem[chan_reg]; // [RQ2]
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  // read data is sampled at the address phase, held into data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_reg <= rd_word;
    end
  end

  // a channel number beyond the last channel falls back to zero
  assign chan_wr = (hwdata[CHAN_LSB +: CHAN_W] < CHAN_W'(N_CHAN)) ?
                   hwdata[CHAN_LSB +: CHAN_W] : '0;

  // mode register; a new write always wins over the hardware clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg      <= OP_IDLE;
      range_reg   <= '0;
      bipolar_reg <= 1'b0;
      word24_reg  <= 1'b1;
      chan_reg    <= '0;
    end else if (mode_wr) begin
      op_reg      <= hwdata[OP_LSB +: OP_W];        // [RQ1]
      range_reg   <= hwdata[RANGE_LSB +: RANGE_W];
      bipolar_reg <= hwdata[BIPOLAR_BIT];
      word24_reg  <= hwdata[WORD24_BIT];
      chan_reg    <= chan_wr;
    end else if (cal_done) begin
      op_reg <= OP_IDLE;                            // [RQ9]
    end else if (conv_valid && op_reg == OP_SINGLE) begin
      op_reg <= OP_IDLE; // single conversion ends after one result
    end
  end

  // filter register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sf_reg   <= SF_RST;
      chop_reg <= 1'b1;
      skip_reg <= 1'b0;
    end else if (filt_wr) begin
      sf_reg   <= hwdata[SF_LSB +: SF_W];
      chop_reg <= hwdata[CHOP_BIT];
      skip_reg <= hwdata[SKIP_BIT];
    end
  end

  // coefficients: calibration result beats a host write the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < N_CHAN; i++) begin
        offs_mem[i] <= OFFS_RST;
        gain_mem[i] <= GAIN_RST;
      end
    end else begin
      if (zs_store) begin
        offs_mem[chan_reg] <= filt_data;          // [RQ4] [RQ16]
      end else if (offs_wr) begin
        offs_mem[chan_reg] <= hwdata[COEF_W-1:0]; // [RQ2]
      end
      if (fs_store) begin
        gain_mem[chan_reg] <= filt_data;          // [RQ4]
      end else if (gain_wr) begin
        gain_mem[chan_reg] <= hwdata[COEF_W-1:0]; // [RQ2]
      end
    end
  end

  // modulator cycle strobe from the master clock
  acs_tick_div #(.W(MOD_DIV_W)) u_mod_div (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (1'b1),
    .clr   (1'b0),
    .div   (MOD_DIV_W'(MOD_DIV)),
    .tick  (mod_tick)
  );

  // output period; skip plays no part, so the second filter stage
  // always sets the pace and calibration time ignores skip [RQ19]
  assign per_len = chop_reg ? PER_W'({2'h0, sf_reg} * PER_W'(CHOP_MULT))
                            : PER_W'(sf_reg);

  // output-rate strobe, realigned while a calibration is armed and on
  // a filter write, so a shorter period never strands the count past it
  acs_tick_div #(.W(PER_W)) u_out_div (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (mod_tick),
    .clr   (state_reg == ACS_ARM || filt_wr),
    .div   (per_len),
    .tick  (out_tick)
  );

  // step length; internal full-scale splits its time in two steps
  always_comb begin
    if (op_reg == OP_INT_FS) begin
      step_len = chop_reg ? CNT_W'(CAL_IFS_CHOP / IFS_STEPS)     // [RQ8]
                          : CNT_W'(CAL_IFS_NOCHOP / IFS_STEPS);
    end else begin
      step_len = chop_reg ? CNT_W'(CAL_ZS_CHOP)                  // [RQ7]
                          : CNT_W'(CAL_ZS_NOCHOP);
    end
  end

  assign in_cal    = (state_reg == ACS_ZS) || (state_reg == ACS_FS);
  assign cal_start = (state_reg == ACS_ARM) && mod_tick && !mode_wr;
  assign last_tick = in_cal && out_tick && !mode_wr &&
                     (cnt_reg == step_len - CNT_W'(1));
  assign zs_store  = last_tick && (state_reg == ACS_ZS);
  assign fs_store  = last_tick && (state_reg == ACS_FS);
  assign cal_done  = fs_store ||
                     (zs_store && op_reg != OP_INT_FS);
  assign conv_valid = (state_reg == ACS_CONV) && out_tick && !mode_wr;

  // sequencer; any mode write restarts it, even mid-calibration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ACS_IDLE;
      cnt_reg   <= '0;
    end else if (mode_wr) begin
      cnt_reg <= '0;
      if (hwdata[OP_LSB + OP_CAL_BIT]) begin
        state_reg <= ACS_ARM;                    // [RQ1]
      end else if (hwdata[OP_LSB +: OP_W] == OP_CONT ||
                   hwdata[OP_LSB +: OP_W] == OP_SINGLE) begin
        state_reg <= ACS_CONV;                   // [RQ11]
      end else begin
        state_reg <= ACS_IDLE;
      end
    end else begin
      unique case (state_reg)
        ACS_IDLE: state_reg <= ACS_IDLE;
        ACS_CONV: begin
          if (conv_valid && op_reg == OP_SINGLE) begin
            state_reg <= ACS_IDLE;
          end
        end
        ACS_ARM: begin
          // wait for a modulator edge so every period counts whole
          if (mod_tick) begin
            cnt_reg   <= '0;
            state_reg <= (op_reg == OP_SYS_FS) ? ACS_FS : ACS_ZS;
          end
        end
        ACS_ZS: begin
          if (last_tick) begin
            cnt_reg   <= '0;
            // internal full-scale runs its zero-scale step first
            state_reg <= (op_reg == OP_INT_FS) ? ACS_FS : ACS_IDLE;
          end else if (out_tick) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        ACS_FS: begin
          if (last_tick) begin
            cnt_reg   <= '0;
            state_reg <= ACS_IDLE;
          end else if (out_tick) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        default: state_reg <= ACS_IDLE; // illegal one-hot code
      endcase
    end
  end

  // ready: a new result wins over the read that releases it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_n_reg <= 1'b1;
    end else if (cal_start) begin
      ready_n_reg <= 1'b1;              // [RQ10] [RQ12]
    end else if (cal_done || conv_valid) begin
      ready_n_reg <= 1'b0;              // [RQ10]
    end else if (data_rd) begin
      ready_n_reg <= 1'b1;
    end
  end
  assign ready_n = ready_n_reg;

  // front end steering during calibration
  always_comb begin
    in_sel = ACS_IN_PINS;             // [RQ24] [RQ25]
    if (state_reg == ACS_ZS &&
        (op_reg == OP_INT_ZS || op_reg == OP_INT_FS)) begin
      in_sel = ACS_IN_SHORT;          // [RQ6] [RQ16]
    end else if (state_reg == ACS_FS && op_reg == OP_INT_FS) begin
      in_sel = ACS_IN_REF;            // [RQ15]
    end
  end
  assign pga_gain = range_reg;            // [RQ21]
  assign skip_eff = skip_reg && !in_cal;  // [RQ19]
  assign chop_out = chop_reg;

  // scaling in 33 bits; gain 800000 is unity, coefficients do not
  // depend on the output rate so a rate change keeps them [RQ23]
  always_comb begin
    diff = ACC_W'($signed({1'b0, filt_data})) -
           ACC_W'($signed({1'b0, offs_mem[chan_reg]}));       // [RQ3]
    prod = diff * $signed({1'b0, gain_mem[chan_reg]});        // [RQ3]
    acc  = prod[GAIN_FRAC +: ACC_W];                          // [RQ5]
    if (bipolar_reg) begin
      acc = acc + ACC_W'(BIPOLAR_MID);                        // [RQ14]
    end
    if (acc < 0) begin
      code = '0;
    end else if (acc > ACC_W'(CODE_MAX)) begin
      code = CODE_MAX;
    end else begin
      code = acc[COEF_W-1:0];
    end
  end

  // result word; no result is ever issued from a calibration state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= '0;
      valid_reg  <= 1'b0;
    end else begin
      valid_reg <= conv_valid;                                // [RQ11]
      if (conv_valid) begin
        result_reg <= word24_reg ? code
                    : {{W16_DROP{1'b0}}, code[COEF_W-1:W16_DROP]}; // [RQ5]
      end
    end
  end
  assign result_valid = valid_reg;
  assign result_data  = result_reg;

  // checks
  ready_cal_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
    in_cal && $past(in_cal) |-> ready_n)
    else $error("ready low during calibration");
  mode_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
    cal_done && !mode_wr |=> op_reg == OP_IDLE && ready_n == 1'b0)
    else $error("op-select or ready not restored after calibration");
  cal_no_res_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ11]
    in_cal |=> !result_valid)
    else $error("result issued during calibration");
  arm_rise_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
    (state_reg == ACS_ARM) && !mode_wr |-> ##[1:ARM_MAX]
    (ready_n || state_reg != ACS_ARM))
    else $error("ready not raised within a modulator cycle");
  mod_period_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
    mod_tick |-> ##ARM_MAX mod_tick)
    else $error("modulator strobe off period");
  offs_store_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
    zs_store |=> offs_mem[$past(chan_reg)] == $past(filt_data))
    else $error("zero-scale result not stored as offset");
  gain_store_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
    fs_store |=> gain_mem[$past(chan_reg)] == $past(filt_data))
    else $error("full-scale result not stored as gain");
  step_len_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
    in_cal |-> cnt_reg < step_len)
    else $error("calibration step ran past its length");
  ifs_steps_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ16]
    zs_store && op_reg == OP_INT_FS && !mode_wr |=> state_reg == ACS_FS)
    else $error("internal full-scale skipped its second step");
  short_in_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6]
    state_reg == ACS_ZS && op_reg == OP_INT_ZS |-> in_sel == ACS_IN_SHORT)
    else $error("inputs not shorted in internal zero-scale");
  skip_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ19]
    in_cal |-> !skip_eff && pga_gain == range_reg)
    else $error("skip or gain wrong during calibration");

  izs_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    cal_done && op_reg == OP_INT_ZS);
  ifs_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    cal_done && op_reg == OP_INT_FS);
  sfs_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    cal_done && op_reg == OP_SYS_FS);
  conv_res_c: cover property (@(posedge clk) disable iff (!rst_n)
    result_valid && bipolar_reg);
endmodule : acs_cal_seq

// ==== core/acs_pkg.sv ====
package acs_pkg;
  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] FILT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0c;
  localparam logic [7:0] OFFS_OFS = 8'h10;
  localparam logic [7:0] GAIN_OFS = 8'h14;
  localparam int DEC_W = 8; // decoded low address bits
  // mode register fields
  localparam int OP_LSB      = 0;
  localparam int OP_W        = 3;
  localparam int RANGE_LSB   = 4;
  localparam int RANGE_W     = 3;
  localparam int BIPOLAR_BIT = 7;
  localparam int WORD24_BIT  = 8;
  localparam int CHAN_LSB    = 9;
  localparam int CHAN_W      = 2;
  // filter register fields
  localparam int SF_LSB   = 0;
  localparam int SF_W     = 12;
  localparam int CHOP_BIT = 12;
  localparam int SKIP_BIT = 13;
  localparam logic [SF_W-1:0] SF_RST = 12'h200;
  // status register fields
  localparam int ST_RDYN_BIT = 0;
  localparam int ST_CAL_BIT  = 1;
  localparam int ST_FS_BIT   = 2;
  // operating codes written into the op-select field
  localparam logic [OP_W-1:0] OP_IDLE   = 3'h0;
  localparam logic [OP_W-1:0] OP_CONT   = 3'h1;
  localparam logic [OP_W-1:0] OP_SINGLE = 3'h2;
  localparam logic [OP_W-1:0] OP_INT_ZS = 3'h4;
  localparam logic [OP_W-1:0] OP_INT_FS = 3'h5;
  localparam logic [OP_W-1:0] OP_SYS_ZS = 3'h6;
  localparam logic [OP_W-1:0] OP_SYS_FS = 3'h7;
  localparam int OP_CAL_BIT = 2; // set for every calibration code
  // timing: one modulator cycle is sixteen master clocks
  localparam int MOD_DIV   = 16;
  localparam int MOD_DIV_W = 4;
  localparam int PER_W     = 14;  // output period in modulator cycles
  localparam int CHOP_MULT = 3;   // chop stretches the output period
  // calibration lengths in output periods
  localparam int CNT_W          = 6;
  localparam int CAL_ZS_CHOP    = 22;
  localparam int CAL_ZS_NOCHOP  = 24;
  localparam int CAL_IFS_CHOP   = 44;
  localparam int CAL_IFS_NOCHOP = 48;
  localparam int IFS_STEPS      = 2;
  // coefficient storage and scaling
  localparam int N_CHAN    = 3;
  localparam int COEF_W    = 24;
  localparam int ACC_W     = 33;
  localparam int GAIN_FRAC = 23;
  localparam logic [COEF_W-1:0] OFFS_RST    = 24'h000000;
  localparam logic [COEF_W-1:0] GAIN_RST    = 24'h800000;
  localparam logic [COEF_W-1:0] BIPOLAR_MID = 24'h800000;
  localparam logic [COEF_W-1:0] CODE_MAX    = 24'hffffff;
  localparam int W16_DROP = 8; // low bits dropped in 16-bit mode
  // analog input steering
  typedef enum logic [1:0] {
    ACS_IN_PINS  = 2'h0,
    ACS_IN_SHORT = 2'h1,
    ACS_IN_REF   = 2'h2
  } acs_in_t;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ACS_IDLE = 5'h01,
    ACS_CONV = 5'h02,
    ACS_ARM  = 5'h04,
    ACS_ZS   = 5'h08,
    ACS_FS   = 5'h10
  } acs_state_t;
endpackage : acs_pkg

// ==== core/acs_tick_div.sv ====
`timescale 1ns/1ps
module acs_tick_div #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // count control
  input  wire logic         en,
  input  wire logic         clr,
  input  wire logic [W-1:0] div,
  // one-cycle strobe every div enabled cycles
  output logic              tick
);
  logic [W-1:0] cnt_reg; // enabled cycles since last strobe

  // strobe on the last enabled cycle of each period
  assign tick = en && !clr && (cnt_reg == div - W'(1));

  // count enabled cycles; clear realigns the period to a start
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else if (en) begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  // the counter never runs past the period
  cnt_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (div != '0) && (cnt_reg < div) |=> (cnt_reg < div))
    else $error("tick divider count ran past its period");
endmodule : acs_tick_div

// ==== verif/acs_filt_model.sv ====
`timescale 1ns/1ps
module acs_filt_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // modulator strobe and word chosen by the bench
  input  wire logic                       mod_tick,
  input  wire logic [acs_pkg::COEF_W-1:0] word_in,
  // filtered word towards the sequencer
  output logic      [acs_pkg::COEF_W-1:0] filt_data
);
  import acs_pkg::*;
  // word moves only on modulator strobes, as a decimator output would;
  // a bench change between strobes is therefore never seen mid-period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_data <= '0;
    end else if (mod_tick) begin
      filt_data <= word_in;
    end
  end
endmodule : acs_filt_model

// ==== verif/acs_cal_seq_tb.sv ====
`timescale 1ns/1ps
module acs_cal_seq_tb;
  import acs_pkg::*;
  // bus master side, driven at rising edges
  logic              clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0]       haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]        htrans = 0;
  logic              hready, hreadyout, hresp, mod_tick, skip_eff;
  logic              chop_out, ready_n, result_valid;
  logic [COEF_W-1:0] filt_data, result_data, fword = 0;
  logic [RANGE_W-1:0] pga_gain;
  acs_in_t           in_sel;
  int                bad_count = 0, comparisons = 0, cyc = 0, nres = 0;
  // single slave: its readyout is the bus ready
  assign hready = hreadyout;
  always #5 clk = ~clk;
  acs_cal_seq i_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .filt_data, .mod_tick, .in_sel, .pga_gain, .skip_eff, .chop_out,
    .ready_n, .result_valid, .result_data);
  acs_filt_model i_filt (.clk, .rst_n, .mod_tick, .word_in(fword),
    .filt_data);
  // results counted so a calibration can prove it made none
  always @(posedge clk) if (result_valid === 1'b1) nres <= nres + 1;
  // hang guard: whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, seen);
    end
  endtask : chk
  // one single ahb-lite transfer; read data taken at data-phase edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask : ahb
  // reset values, coefficient read/write, unmapped place
  task regs;
    logic [7:0]  a [5];
    logic [31:0] e [5];
    a = '{MODE_OFS, FILT_OFS, OFFS_OFS, GAIN_OFS, 8'h40};
    e = '{32'h100, 32'h1200, 32'h0, 32'h800000, 32'h0};
    chk("rdy_rst", ready_n, 1'b1);
    foreach (a[i]) begin
      ahb(0, a[i], 0, rd);
      chk("reg_rst", rd, e[i]);
    end
    ahb(1, OFFS_OFS, 32'habcdef, rd);
    ahb(1, GAIN_OFS, 32'h123456, rd);
    ahb(1, 8'h40, 32'h5a5a5a, rd);
    e = '{32'h100, 32'h1200, 32'habcdef, 32'h123456, 32'h0};
    foreach (a[i]) begin
      ahb(0, a[i], 0, rd);
      chk("reg_rw", rd, e[i]);
    end
  endtask : regs
  // start a calibration and time it from the write to ready low
  task cal(input logic [31:0] md, input int len, input acs_in_t isel);
    int n;
    nres = 0;
    ahb(1, MODE_OFS, md, rd);
    // ready is not trusted for one modulator cycle after the command
    repeat (17) @(posedge clk);
    #1;
    chk("rdy_hi", ready_n, 1'b1);
    chk("in_sel", in_sel, isel);
    chk("pga", pga_gain, md[6:4]);
    chk("skip", skip_eff, 1'b0);
    ahb(0, STAT_OFS, 0, rd);
    chk("stat", rd, {29'h0, md[2:0] == OP_SYS_FS, 2'h3});
    n = 20;
    // the reference step of an internal full-scale sits in its 2nd half
    if (md[2:0] == OP_INT_FS) begin
      repeat (len / 2) @(posedge clk);
      #1;
      chk("in_ref", in_sel, ACS_IN_REF);
      n = n + len / 2;
    end
    while (ready_n !== 1'b0 && n < len + 40) begin
      @(posedge clk) #1;
      n++;
    end
    chk("cal_len", n >= len && n <= len + 18, 1'b1);
    chk("no_result", nres, 0);
    ahb(0, MODE_OFS, 0, rd);
    chk("op_idle", rd[2:0], OP_IDLE);
  endtask : cal
  // single conversion with a known filter word
  task conv(input logic [31:0] md, input logic [23:0] w,
            input logic [31:0] e);
    int n;
    fword <= w;
    repeat (20) @(posedge clk);
    ahb(1, MODE_OFS, md, rd);
    n = 0;
    while (result_valid !== 1'b1 && n < 300) begin
      @(posedge clk) #1;
      n++;
    end
    chk("result", result_data, e);
    chk("rdy_res", ready_n, 1'b0);
    ahb(0, DATA_OFS, 0, rd);
    chk("data_rd", rd, e);
    chk("rdy_rel", ready_n, 1'b1);
  endtask : conv
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    regs();
    ahb(1, FILT_OFS, 32'h1, rd);
    fword <= 24'h7fff00;
    // internal full-scale kept off the two lowest range codes
    cal(32'h125, 48 * 16, ACS_IN_SHORT);
    ahb(0, OFFS_OFS, 0, rd);
    chk("offs_ifs", rd, 32'h7fff00);
    ahb(0, GAIN_OFS, 0, rd);
    chk("gain_ifs", rd, 32'h7fff00);
    // zero-scale follows the internal full-scale
    ahb(1, FILT_OFS, 32'h1001, rd);
    fword <= 24'h000100;
    cal(32'h104, 22 * 48, ACS_IN_SHORT);
    chk("chop_on", chop_out, 1'b1);
    ahb(0, OFFS_OFS, 0, rd);
    chk("offs_izs", rd, 32'h100);
    // system zero before system full, chop as later used
    ahb(1, FILT_OFS, 32'h2001, rd);
    cal(32'h136, 24 * 16, ACS_IN_PINS);
    chk("chop_off", chop_out, 1'b0);
    fword <= 24'h400000;
    cal(32'h137, 24 * 16, ACS_IN_PINS);
    ahb(0, GAIN_OFS, 0, rd);
    chk("gain_sfs", rd, 32'h400000);
    conv(32'h182, 24'h000100, 32'h800000);
    conv(32'h182, 24'h000500, 32'h800200);
    conv(32'h082, 24'h000500, 32'h008002);
    print_verdict();
  end
endmodule : acs_cal_seq_tb
